// file: design/ksp_pkg.sv
// Constants, types and reset values of the key-scan port block
// How it works
// R1: Key input port pins read at bank-0 data address 70H.
// R2: In standby, any low key-return input pin raises wake.
// R3: Per-bit direction of bit-direction port one at control nibble 26H.
// R4: Ports one, group one and two drive open-drain: latch 0 pulls low.
// R5: Reading an output-mode bit returns its latch, not the pin.
// R6: Data of ports at 71H, 72H, 73H; write loads latch, read mixes.
// R7: Pull-up on in input mode, off in output mode, for those ports.
// R8: Reset puts every bit of bit-direction port one in input mode.
// R9: Group port one direction follows bit 2 of nibble 37H.
// R10: Group port two direction follows bit 3 of nibble 37H.
// R11: Reset makes both group ports outputs with cleared latches.
// R12: Port two direction per bit at nibble 27H; data at 6FH.
// R13: Port two pull-ups per bit at 17H; stay on in output mode.
// R14: Reset puts every bit of bit-direction port two in input mode.
// R15: Single-bit port direction fixed at build; data at bank-1 70H; no wake.
// R16: Reset releases the single-bit port output.
// R17: Chosen edge of interrupt pin sets flag at nibble 3EH bit 0.
// R18: Live interrupt pin level reads at nibble 0FH bit 0.
// R19: Turning a pin to output drives its existing latch at once.
// R20: Control space 00H-3FH ignores bank; 40H-7FH aliases data memory.
// R21: Read op copies nibble to window; write op copies window in.
// R22: Writes to read-only or unused nibbles do nothing.
// R23: Software clears port two pull-up enables itself when wanted.
// R24: All pin inputs pass a two-stage synchroniser before use.
package ksp_pkg;

   // Data memory port register addresses
   localparam logic [6:0] ADDR_PORT_E   = 7'h6f;
   localparam logic [6:0] ADDR_PORT_A   = 7'h70;
   localparam logic [6:0] ADDR_PORT_B   = 7'h71;
   localparam logic [6:0] ADDR_PORT_C   = 7'h72;
   localparam logic [6:0] ADDR_PORT_D   = 7'h73;
   localparam logic [6:0] ADDR_SBP      = 7'h70;

   // Control nibble addresses
   localparam logic [6:0] RF_PU_E       = 7'h17;
   localparam logic [6:0] RF_DIR_B      = 7'h26;
   localparam logic [6:0] RF_DIR_E      = 7'h27;
   localparam logic [6:0] RF_GRP_DIR    = 7'h37;
   localparam logic [6:0] RF_IRQ        = 7'h3e;
   localparam logic [6:0] RF_INT_LVL    = 7'h0f;

   // Field positions
   localparam int         GRP_C_BIT     = 2;
   localparam int         GRP_D_BIT     = 3;
   localparam int         RF_ALIAS_BIT  = 6;

   // Reset values
   localparam logic [3:0] DIR_RST       = 4'h0;
   localparam logic [3:0] PU_E_RST      = 4'h0;
   localparam logic [3:0] LATCH_RST     = 4'h0;
   localparam logic       GRP_RST       = 1'b1;
   localparam logic       SBP_LATCH_RST = 1'b1;

   // Synchronised pin inputs
   typedef struct packed {
      logic [3:0] a;
      logic [3:0] b;
      logic [3:0] c;
      logic [3:0] d;
      logic [3:0] e;
      logic       sbp;
      logic       intp;
   } ksp_pins_t;

   // Pin drive: open-drain ports have out, oe; pull-up enables
   typedef struct packed {
      logic [3:0] b_out;
      logic [3:0] b_oe;
      logic [3:0] b_pu;
      logic [3:0] c_out;
      logic [3:0] c_oe;
      logic [3:0] c_pu;
      logic [3:0] d_out;
      logic [3:0] d_oe;
      logic [3:0] d_pu;
      logic [3:0] e_out;
      logic [3:0] e_oe;
      logic [3:0] e_pu;
      logic       sbp_out;
      logic       sbp_oe;
   } ksp_drive_t;

   // Whole state of the port block
   typedef struct packed {
      logic [3:0] latch_b;
      logic [3:0] latch_c;
      logic [3:0] latch_d;
      logic [3:0] latch_e;
      logic       latch_sbp;
      logic [3:0] dir_b;
      logic [3:0] dir_e;
      logic [3:0] pu_e;
      logic       grp_c;
      logic       grp_d;
      logic       irq;
      logic       int_prev;
      logic       edge_armed;
      ksp_drive_t drive;
      logic [3:0] dm_rdata;
      logic       dm_hit;
      logic [3:0] win_data;
      logic       win_load;
      logic       rf_mem_alias;
      logic       wake;
   } ksp_state_t;

   // Drive after reset: groups low, others released, pull-ups per mode except port two, whose pull-ups are off
   localparam ksp_drive_t DRIVE_RST = '{
      b_out: 4'h0, b_oe: 4'h0, b_pu: 4'hf,
      c_out: 4'h0, c_oe: 4'hf, c_pu: 4'h0,
      d_out: 4'h0, d_oe: 4'hf, d_pu: 4'h0,
      e_out: 4'h0, e_oe: 4'h0, e_pu: 4'h0,
      sbp_out: 1'b0, sbp_oe: 1'b0};

   localparam ksp_state_t STATE_RST = '{
      latch_b: LATCH_RST, latch_c: LATCH_RST, latch_d: LATCH_RST,
      latch_e: LATCH_RST, latch_sbp: SBP_LATCH_RST,
      dir_b: DIR_RST, dir_e: DIR_RST, pu_e: PU_E_RST,
      grp_c: GRP_RST, grp_d: GRP_RST, irq: 1'b0, int_prev: 1'b0,
      edge_armed: 1'b0, drive: DRIVE_RST, dm_rdata: 4'h0, dm_hit: 1'b0,
      win_data: 4'h0, win_load: 1'b0, rf_mem_alias: 1'b0, wake: 1'b0};

endpackage : ksp_pkg

// file: design/ksp_port_block.sv
// Key-scan port block: port latches, directions, pull-ups, interrupt pin
`timescale 1ns/100ps
module ksp_port_block #(
   parameter bit SBP_OUTPUT = 1'b1
) (
   input  wire logic               clk,
   input  wire logic               rst_n,
   input  wire ksp_pkg::ksp_pins_t pins_in,
   output ksp_pkg::ksp_drive_t     drive,
   input  wire logic               dm_rd,
   input  wire logic               dm_wr,
   input  wire logic               dm_bank,
   input  wire logic [6:0]         dm_addr,
   input  wire logic [3:0]         dm_wdata,
   output logic      [3:0]         dm_rdata,
   output logic                    dm_hit,
   input  wire logic               rf_rd,
   input  wire logic               rf_wr,
   input  wire logic [6:0]         rf_addr,
   input  wire logic [3:0]         win_value,
   output logic      [3:0]         win_data,
   output logic                    win_load,
   output logic                    rf_mem_alias,
   input  wire logic               int_edge_rising,
   input  wire logic               standby,
   output logic                    wake,
   output logic                    irq_flag
);

   ksp_pkg::ksp_state_t q_reg;
   ksp_pkg::ksp_state_t q_next;
   ksp_pkg::ksp_pins_t  pins_s;

   // Bit read: latch where output, synchronised pin where input
   function automatic logic [3:0] port_read(input logic [3:0] dir,
                                            input logic [3:0] latch,
                                            input logic [3:0] pin);
      port_read = (dir & latch) | (~dir & pin);
   endfunction : port_read

   // Open-drain enable: pull low only for an output bit with latch 0
   function automatic logic [3:0] od_enable(input logic [3:0] dir,
                                            input logic [3:0] latch);
      od_enable = dir & ~latch;
   endfunction : od_enable

   // Pin inputs resynchronised before any use
   ksp_sync #(
      .W ($bits(ksp_pkg::ksp_pins_t))
   ) u_sync (
      .clk   (clk),
      .rst_n (rst_n),
      .d     (pins_in),
      .q     (pins_s)                                                    // R24
   );

   // Next-state logic
   always_comb
   begin
      logic       m_wr;
      logic       m_bank;
      logic [6:0] m_addr;
      logic [3:0] m_data;
      logic       r_bank;
      logic [6:0] r_addr;
      logic [3:0] m_rval;
      logic       m_rhit;
      logic [3:0] c_rval;
      logic       int_edge;
      logic [3:0] dir_c;
      logic [3:0] dir_d;
      m_wr     = 1'b0;
      m_bank   = dm_bank;
      m_addr   = dm_addr;
      m_data   = dm_wdata;
      r_bank   = dm_bank;
      r_addr   = dm_addr;
      m_rval   = 4'h0;
      m_rhit   = 1'b0;
      c_rval   = 4'h0;
      int_edge = 1'b0;
      dir_c    = 4'h0;
      dir_d    = 4'h0;

      q_next              = q_reg;
      q_next.win_load     = 1'b0;
      q_next.rf_mem_alias = 1'b0;
      q_next.edge_armed   = 1'b1;
      q_next.int_prev     = pins_s.intp;

      // Upper half of control space reaches data memory in current bank
      if (rf_wr && rf_addr[ksp_pkg::RF_ALIAS_BIT])                       // R20
      begin
         m_wr   = 1'b1;
         m_addr = rf_addr;
         m_data = win_value;                                             // R21
      end
      else if (dm_wr)
      begin
         m_wr = 1'b1;
      end
      if (rf_rd && rf_addr[ksp_pkg::RF_ALIAS_BIT])
         r_addr = rf_addr;                                               // R20

      // Port register read decode
      if (!r_bank)
      begin
         case (r_addr)
            ksp_pkg::ADDR_PORT_A:
            begin
               m_rval = pins_s.a;                                        // R1
               m_rhit = 1'b1;
            end
            ksp_pkg::ADDR_PORT_B:
            begin
               m_rval = port_read(q_reg.dir_b, q_reg.latch_b, pins_s.b); // R5 R6
               m_rhit = 1'b1;
            end
            ksp_pkg::ADDR_PORT_C:
            begin
               m_rval = port_read({4{q_reg.grp_c}}, q_reg.latch_c, pins_s.c);
               m_rhit = 1'b1;
            end
            ksp_pkg::ADDR_PORT_D:
            begin
               m_rval = port_read({4{q_reg.grp_d}}, q_reg.latch_d, pins_s.d);
               m_rhit = 1'b1;
            end
            ksp_pkg::ADDR_PORT_E:
            begin
               m_rval = port_read(q_reg.dir_e, q_reg.latch_e, pins_s.e); // R12
               m_rhit = 1'b1;
            end
            default:
            begin
               m_rval = 4'h0;
               m_rhit = 1'b0;
            end
         endcase
      end
      else if (r_addr == ksp_pkg::ADDR_SBP)
      begin
         m_rval = {3'h0, SBP_OUTPUT ? q_reg.latch_sbp : pins_s.sbp};   // R15
         m_rhit = 1'b1;
      end

      // Port register write decode; key input port is read-only
      if (m_wr)
      begin
         if (!m_bank)
         begin
            case (m_addr)
               ksp_pkg::ADDR_PORT_B: q_next.latch_b = m_data;           // R6
               ksp_pkg::ADDR_PORT_C: q_next.latch_c = m_data;           // R6
               ksp_pkg::ADDR_PORT_D: q_next.latch_d = m_data;           // R6
               ksp_pkg::ADDR_PORT_E: q_next.latch_e = m_data;           // R12
               default:              q_next.latch_b = q_reg.latch_b;    // R22
            endcase
         end
         else if (m_addr == ksp_pkg::ADDR_SBP)
         begin
            q_next.latch_sbp = m_data[0];                                // R15
         end
      end

      // Data memory side answer
      if (dm_rd)
      begin
         q_next.dm_rdata = m_rval;
         q_next.dm_hit   = m_rhit;
      end

      // Control nibble read decode, bank ignored
      case (rf_addr)
         ksp_pkg::RF_PU_E:    c_rval = q_reg.pu_e;                       // R13
         ksp_pkg::RF_DIR_B:   c_rval = q_reg.dir_b;                      // R3
         ksp_pkg::RF_DIR_E:   c_rval = q_reg.dir_e;                      // R12
         ksp_pkg::RF_GRP_DIR: c_rval = {q_reg.grp_d, q_reg.grp_c, 2'h0};
         ksp_pkg::RF_IRQ:     c_rval = {3'h0, q_reg.irq};
         ksp_pkg::RF_INT_LVL: c_rval = {3'h0, pins_s.intp};              // R18
         default:             c_rval = 4'h0;                             // R22
      endcase

      // Read op loads the window register
      if (rf_rd)
      begin
         q_next.win_load = 1'b1;                                         // R21
         if (rf_addr[ksp_pkg::RF_ALIAS_BIT])
         begin
            q_next.win_data     = m_rval;
            q_next.rf_mem_alias = !m_rhit;                               // R20
         end
         else
         begin
            q_next.win_data = c_rval;
         end
      end

      // Write op stores the window into control nibbles
      if (rf_wr && !rf_addr[ksp_pkg::RF_ALIAS_BIT])
      begin
         case (rf_addr)
            ksp_pkg::RF_PU_E:  q_next.pu_e  = win_value;                 // R13
            ksp_pkg::RF_DIR_B: q_next.dir_b = win_value;                 // R3
            ksp_pkg::RF_DIR_E: q_next.dir_e = win_value;                 // R12
            ksp_pkg::RF_GRP_DIR:
            begin
               q_next.grp_c = win_value[ksp_pkg::GRP_C_BIT];             // R9
               q_next.grp_d = win_value[ksp_pkg::GRP_D_BIT];             // R10
            end
            ksp_pkg::RF_IRQ:   q_next.irq   = win_value[0];
            default:           q_next.irq   = q_next.irq;                // R22
         endcase
      end
      if (rf_wr && rf_addr[ksp_pkg::RF_ALIAS_BIT])
         q_next.rf_mem_alias = 1'b1;                                     // R20

      // Interrupt edge detect; a set beats a clear in the same cycle
      if (int_edge_rising)
         int_edge = pins_s.intp & ~q_reg.int_prev;
      else
         int_edge = ~pins_s.intp & q_reg.int_prev;
      if (q_reg.edge_armed && int_edge)
         q_next.irq = 1'b1;                                              // R17

      // Wake request from any low key-return input
      dir_c = {4{q_reg.grp_c}};
      dir_d = {4{q_reg.grp_d}};
      q_next.wake = standby &&                                           // R2
                    ((|(~pins_s.a)) ||
                     (|(~pins_s.b & ~q_reg.dir_b)) ||
                     (|(~pins_s.c & ~dir_c)) ||
                     (|(~pins_s.d & ~dir_d)));                           // R15

      // Pin drive follows new mode and latch in the same edge
      q_next.drive.b_out   = 4'h0;
      q_next.drive.c_out   = 4'h0;
      q_next.drive.d_out   = 4'h0;
      q_next.drive.sbp_out = 1'b0;
      q_next.drive.b_oe    = od_enable(q_next.dir_b, q_next.latch_b);   // R4 R19
      q_next.drive.c_oe    = od_enable({4{q_next.grp_c}}, q_next.latch_c); // R4
      q_next.drive.d_oe    = od_enable({4{q_next.grp_d}}, q_next.latch_d); // R4
      q_next.drive.b_pu    = ~q_next.dir_b;                              // R7
      q_next.drive.c_pu    = {4{~q_next.grp_c}};                         // R7
      q_next.drive.d_pu    = {4{~q_next.grp_d}};                         // R7
      q_next.drive.e_out   = q_next.latch_e;                             // R19
      q_next.drive.e_oe    = q_next.dir_e;
      q_next.drive.e_pu    = q_next.pu_e;                                // R13
      q_next.drive.sbp_oe  = SBP_OUTPUT & ~q_next.latch_sbp;             // R15
   end

   // State register; reset sets modes, latches and drive
   always_ff @(posedge clk)
   begin
      if (!rst_n)
         q_reg <= ksp_pkg::STATE_RST;                                    // R8 R11 R14 R16
      else
         q_reg <= q_next;
   end

   // Outputs straight from the state register
   assign drive        = q_reg.drive;
   assign dm_rdata     = q_reg.dm_rdata;
   assign dm_hit       = q_reg.dm_hit;
   assign win_data     = q_reg.win_data;
   assign win_load     = q_reg.win_load;
   assign rf_mem_alias = q_reg.rf_mem_alias;
   assign wake         = q_reg.wake;
   assign irq_flag     = q_reg.irq;

   // Checks on the block behaviour
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   key_read_a: assert property ( // R1
      dm_rd && !dm_bank && dm_addr == ksp_pkg::ADDR_PORT_A
      |=> dm_hit && dm_rdata == $past(pins_s.a))
      else $error("key input port read mismatch");

   wake_key_a: assert property (standby && pins_s.a != 4'hf |=> wake) // R2
      else $error("wake not raised on low key input");

   dir_b_write_a: assert property ( // R3
      rf_wr && rf_addr == ksp_pkg::RF_DIR_B
      |=> q_reg.dir_b == $past(win_value))
      else $error("port one direction not written");

   od_latch_a: assert property ( // R4
      dm_wr && !dm_bank && dm_addr == ksp_pkg::ADDR_PORT_B && !rf_wr
      |=> drive.b_oe == (q_reg.dir_b & ~$past(dm_wdata)))
      else $error("open-drain drive does not follow latch");

   out_readback_a: assert property ( // R5
      dm_rd && !dm_bank && dm_addr == ksp_pkg::ADDR_PORT_B && !dm_wr && !rf_wr && !rf_rd
      |=> (dm_rdata & $past(q_reg.dir_b)) == ($past(q_reg.latch_b) & $past(q_reg.dir_b)))
      else $error("output bit read did not return latch");

   data_write_a: assert property ( // R6
      dm_wr && !dm_bank && dm_addr == ksp_pkg::ADDR_PORT_C && !rf_wr
      |=> q_reg.latch_c == $past(dm_wdata))
      else $error("port data write did not load latch");

   pullup_mode_a: assert property ( // R7
      drive.b_pu == ~q_reg.dir_b && drive.c_pu == {4{~q_reg.grp_c}})
      else $error("pull-up does not follow mode");

   group_c_dir_a: assert property ( // R9
      rf_wr && rf_addr == ksp_pkg::RF_GRP_DIR
      |=> drive.c_oe == ({4{$past(win_value[2])}} & ~q_reg.latch_c))
      else $error("group port one drive wrong after mode write");

   group_dir_a: assert property ( // R10
      rf_wr && rf_addr == ksp_pkg::RF_GRP_DIR
      |=> drive.d_oe == ({4{$past(win_value[3])}} & ~q_reg.latch_d))
      else $error("group port two drive wrong after mode write");

   pullup_write_a: assert property ( // R13
      rf_wr && rf_addr == ksp_pkg::RF_PU_E
      |=> drive.e_pu == $past(win_value))
      else $error("port two pull-up enable not written");

   pullup_hold_a: assert property (drive.e_pu == q_reg.pu_e && drive.e_oe == q_reg.dir_e) // R13
      else $error("port two pull-up dropped");

   sbp_drive_a: assert property ( // R15
      dm_wr && dm_bank && dm_addr == ksp_pkg::ADDR_SBP && !rf_wr
      |=> drive.sbp_oe == (SBP_OUTPUT & ~$past(dm_wdata[0])))
      else $error("single-bit port drive does not follow latch");

   irq_edge_a: assert property ( // R17
      q_reg.edge_armed && !int_edge_rising && q_reg.int_prev && !pins_s.intp
      |=> irq_flag)
      else $error("falling edge did not set interrupt flag");

   int_level_a: assert property ( // R18
      rf_rd && rf_addr == ksp_pkg::RF_INT_LVL
      |=> win_load && win_data == {3'h0, $past(pins_s.intp)})
      else $error("interrupt level read wrong");

   alias_pulse_a: assert property ( // R20
      rf_wr && rf_addr[ksp_pkg::RF_ALIAS_BIT] |=> rf_mem_alias)
      else $error("alias write not handed to data memory");

   unused_write_a: assert property ( // R22
      rf_wr && rf_addr == 7'h05
      |=> $stable(q_reg.dir_b) && $stable(q_reg.pu_e) && $stable(q_reg.dir_e))
      else $error("write to unused nibble changed state");

   wake_cov_c:  cover property (standby ##1 wake);
   irq_cov_c:   cover property ($rose(irq_flag));
   alias_cov_c: cover property (rf_rd && rf_addr == ksp_pkg::ADDR_PORT_B ##1 win_load);
   fall_cov_c:  cover property (!int_edge_rising && q_reg.int_prev && !pins_s.intp ##1 irq_flag);
   mode_cov_c:  cover property (rf_wr && rf_addr == ksp_pkg::RF_GRP_DIR ##1 drive.c_oe != 4'h0);

endmodule : ksp_port_block

// file: design/ksp_sync.sv
// Two-stage synchroniser for the port pin inputs
`timescale 1ns/100ps
module ksp_sync #(
   parameter int W = 22
) (
   input  wire logic         clk,
   input  wire logic         rst_n,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);

   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
   } ksp_sync_t;

   ksp_sync_t st_reg;
   ksp_sync_t st_next;

   // First stage feeds only the second
   always_comb
   begin
      st_next.s1 = d;
      st_next.s2 = st_reg.s1;
   end

   // Stage registers; reset preloads pin levels so no false edge follows
   always_ff @(posedge clk)
   begin
      if (!rst_n)
         st_reg <= '{s1: d, s2: d};
      else
         st_reg <= st_next;
   end

   assign q = st_reg.s2;

endmodule : ksp_sync

// file: testbench/ksp_pins_model.sv
// Key matrix, key-return lines and interrupt source model
`timescale 1ns/100ps
module ksp_pins_model (
   input  wire logic                clk,
   input  wire ksp_pkg::ksp_drive_t drive,
   input  wire logic [15:0]         key_low,
   input  wire logic [3:0]          e_ext,
   input  wire logic                sbp_ext,
   input  wire logic                intp,
   output ksp_pkg::ksp_pins_t       pins
);
   logic flt = 1'b0;

   // Undriven lines without pull-up wander every cycle
   always @(posedge clk)
      flt <= ~flt;

   // Sink wins, then a pressed key, then pull-up or a wandering level
   function automatic logic [3:0] od(input logic [3:0] oe, input logic [3:0] pu,
                                     input logic [3:0] key);
      od = ~oe & ~key & (pu | {4{flt}});
   endfunction : od

   // Resolve every pin from the block's drive and the outside world
   always_comb
   begin
      pins.a    = ~key_low[3:0];
      pins.b    = od(drive.b_oe, drive.b_pu, key_low[7:4]);
      pins.c    = od(drive.c_oe, drive.c_pu, key_low[11:8]);
      pins.d    = od(drive.d_oe, drive.d_pu, key_low[15:12]);
      pins.e    = (drive.e_oe & drive.e_out) | (~drive.e_oe & e_ext);
      pins.sbp  = ~drive.sbp_oe & sbp_ext;
      pins.intp = intp;
   end
endmodule : ksp_pins_model

// file: testbench/ksp_port_block_tb.sv
// Self-checking bench for the key-scan port block
`timescale 1ns/100ps
module ksp_port_block_tb;
   logic                clk = 1'b0;
   logic                rst_n = 1'b0;
   ksp_pkg::ksp_pins_t  pins;
   ksp_pkg::ksp_drive_t drive;
   logic                dm_rd = 1'b0;
   logic                dm_wr = 1'b0;
   logic                dm_bank = 1'b0;
   logic [6:0]          dm_addr = 7'h00;
   logic [3:0]          dm_wdata = 4'h0;
   logic [3:0]          dm_rdata;
   logic                dm_hit;
   logic                rf_rd = 1'b0;
   logic                rf_wr = 1'b0;
   logic [6:0]          rf_addr = 7'h00;
   logic [3:0]          win_value = 4'h0;
   logic [3:0]          win_data;
   logic                win_load;
   logic                rf_mem_alias;
   logic                int_edge_rising = 1'b0;
   logic                standby = 1'b0;
   logic                wake;
   logic                irq_flag;
   logic [15:0]         key_low = 16'h0000;
   logic [3:0]          e_ext = 4'hc;
   logic                sbp_ext = 1'b1;
   logic                intp = 1'b1;
   logic [4:0]          v;
   int                  err_count = 0;
   int                  cmp_count = 0;

   ksp_port_block i_dut (.clk(clk), .rst_n(rst_n), .pins_in(pins), .drive(drive),
      .dm_rd(dm_rd), .dm_wr(dm_wr), .dm_bank(dm_bank), .dm_addr(dm_addr),
      .dm_wdata(dm_wdata), .dm_rdata(dm_rdata), .dm_hit(dm_hit), .rf_rd(rf_rd),
      .rf_wr(rf_wr), .rf_addr(rf_addr), .win_value(win_value), .win_data(win_data),
      .win_load(win_load), .rf_mem_alias(rf_mem_alias),
      .int_edge_rising(int_edge_rising), .standby(standby), .wake(wake),
      .irq_flag(irq_flag));

   ksp_pins_model i_keys (.clk(clk), .drive(drive), .key_low(key_low), .e_ext(e_ext),
      .sbp_ext(sbp_ext), .intp(intp), .pins(pins));

   // 25 MHz clock
   always #20 clk = ~clk;

   // Compare and count
   task automatic check(input logic [4:0] seen, input logic [4:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         err_count++;
         $display("[ERR] %0t ns: seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   // One write strobe: data memory or control space
   task automatic wr(input bit rf, input logic bank, input logic [6:0] a,
                     input logic [3:0] d);
      @(posedge clk);
      dm_wr     <= !rf;
      rf_wr     <= rf;
      dm_bank   <= bank;
      dm_addr   <= a;
      rf_addr   <= a;
      dm_wdata  <= d;
      win_value <= d;
      @(posedge clk);
      dm_wr <= 1'b0;
      rf_wr <= 1'b0;
      @(negedge clk);
   endtask : wr

   // One read strobe; returns hit or load flag above the nibble
   task automatic rd(input bit rf, input logic bank, input logic [6:0] a,
                     output logic [4:0] r);
      @(posedge clk);
      dm_rd   <= !rf;
      rf_rd   <= rf;
      dm_bank <= bank;
      dm_addr <= a;
      rf_addr <= a;
      @(posedge clk);
      dm_rd <= 1'b0;
      rf_rd <= 1'b0;
      @(negedge clk);
      r = rf ? {win_load, win_data} : {dm_hit, dm_rdata};
   endtask : rd

   // Let pin changes cross the synchroniser
   task automatic settle;
      repeat (4) @(posedge clk);
      @(negedge clk);
   endtask : settle

   // Verdict and end of run
   task automatic test_done;
      if (err_count == 0 && cmp_count > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : test_done

   // Watchdog
   initial
   begin
      repeat (3000) @(posedge clk);
      err_count++;
      test_done();
   end

   // Main sequence
   initial
   begin
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
      settle();
      // State after reset
      check({1'b0, drive.b_oe}, 5'h00);
      check({1'b0, drive.b_pu}, 5'h0f);
      check({1'b0, drive.c_oe & drive.d_oe}, 5'h0f);
      check({1'b0, drive.e_oe}, 5'h00);
      check({4'h0, drive.sbp_oe}, 5'h00);
      rd(1, 0, 7'h37, v);
      check(v, 5'h1c);
      rd(1, 0, 7'h27, v);
      check(v, 5'h10);
      rd(0, 0, 7'h72, v);
      check(v, 5'h10);
      // Key input port reads pins
      @(posedge clk);
      key_low <= 16'h0005;
      settle();
      rd(0, 0, 7'h70, v);
      check(v, 5'h1a);
      // Bit-direction port one: latch first, then direction
      wr(0, 0, 7'h71, 4'h6);
      @(posedge clk);
      key_low <= 16'h0080;
      wr(1, 0, 7'h26, 4'h3);
      check({1'b0, drive.b_oe}, 5'h01);
      check({1'b0, drive.b_pu}, 5'h0c);
      check({1'b0, drive.b_out}, 5'h00);
      settle();
      rd(0, 0, 7'h71, v);
      check(v, 5'h16);
      rd(1, 0, 7'h71, v);
      check(v, 5'h16);
      check({4'h0, rf_mem_alias}, 5'h00);
      rd(1, 1, 7'h26, v);
      check(v, 5'h13);
      // Group ports
      wr(1, 0, 7'h37, 4'h0);
      check({1'b0, drive.c_oe}, 5'h00);
      check({1'b0, drive.c_pu}, 5'h0f);
      wr(0, 0, 7'h72, 4'h3);
      check({1'b0, drive.c_oe}, 5'h00);
      wr(0, 0, 7'h73, 4'h5);
      wr(1, 0, 7'h37, 4'h4);
      check({1'b0, drive.c_oe}, 5'h0c);
      check({1'b0, drive.d_oe}, 5'h00);
      wr(1, 0, 7'h37, 4'hc);
      check({1'b0, drive.d_oe}, 5'h0a);
      rd(0, 0, 7'h73, v);
      check(v, 5'h15);
      // Bit-direction port two with pull-ups
      wr(1, 0, 7'h17, 4'hf);
      wr(0, 0, 7'h6f, 4'h1);
      wr(1, 0, 7'h27, 4'h3);
      check({1'b0, drive.e_oe}, 5'h03);
      check({1'b0, drive.e_out & drive.e_oe}, 5'h01);
      check({1'b0, drive.e_pu}, 5'h0f);
      wr(1, 0, 7'h17, 4'hc);
      check({1'b0, drive.e_pu}, 5'h0c);
      settle();
      rd(0, 0, 7'h6f, v);
      check(v, 5'h1d);
      // Single-bit port
      wr(0, 1, 7'h70, 4'h0);
      check({4'h0, drive.sbp_oe}, 5'h01);
      rd(0, 1, 7'h70, v);
      check(v, 5'h10);
      wr(0, 1, 7'h70, 4'h1);
      check({4'h0, drive.sbp_oe}, 5'h00);
      // Refused and unused places
      wr(0, 1, 7'h71, 4'h9);
      rd(0, 1, 7'h71, v);
      check(v, 5'h00);
      wr(1, 0, 7'h05, 4'h9);
      rd(1, 0, 7'h05, v);
      check(v, 5'h10);
      rd(1, 0, 7'h45, v);
      check({4'h0, rf_mem_alias}, 5'h01);
      // Interrupt pin, falling then rising edge
      @(posedge clk);
      intp <= 1'b0;
      settle();
      check({4'h0, irq_flag}, 5'h01);
      rd(1, 0, 7'h0f, v);
      check(v, 5'h10);
      wr(1, 0, 7'h3e, 4'h0);
      check({4'h0, irq_flag}, 5'h00);
      @(posedge clk);
      int_edge_rising <= 1'b1;
      intp <= 1'b1;
      settle();
      rd(1, 0, 7'h3e, v);
      check(v, 5'h11);
      rd(1, 0, 7'h0f, v);
      check(v, 5'h11);
      // Standby wake sources
      @(posedge clk);
      key_low <= 16'h0000;
      standby <= 1'b1;
      settle();
      check({4'h0, wake}, 5'h00);
      @(posedge clk);
      sbp_ext <= 1'b0;
      settle();
      check({4'h0, wake}, 5'h00);
      @(posedge clk);
      key_low <= 16'h0001;
      settle();
      check({4'h0, wake}, 5'h01);
      @(posedge clk);
      key_low <= 16'h0040;
      settle();
      check({4'h0, wake}, 5'h01);
      @(posedge clk);
      key_low <= 16'h0000;
      settle();
      check({4'h0, wake}, 5'h00);
      test_done();
   end
endmodule : ksp_port_block_tb
